// [core/rtab_core.sv]
// Summary of operation
// - other-bus valid command aborts, resets processing
// - reply goes out on new command's bus
// - accept any address zero through thirty
// - address comes from connector strap pins
// - sample and check address after power-up
// - no single fault validates wrong address
// - invalid address silences every response
// - one bus active, except superseding case
// - all-ones address reserved, never unique
`timescale 1ns/1ps
module rtab_core
   import rtab_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // connector strap pins, asynchronous
   input wire logic [4:0] strap_addr,
   input wire logic strap_parity,
   // decoded commands from bus a
   input wire logic cmd_valid_a,
   input wire logic [4:0] cmd_addr_a,
   // decoded commands from bus b
   input wire logic cmd_valid_b,
   input wire logic [4:0] cmd_addr_b,
   // end of the current message from the message logic
   input wire logic msg_done,
   // address status
   output logic addr_valid,
   output logic addr_fail,
   output logic [4:0] own_addr,
   // message control
   output logic msg_active,
   output logic active_bus,
   output logic msg_reset,
   output logic reply_req,
   output logic reply_bus,
   output logic bcast_rx
);
   // filtered strap pins
   logic [5:0] strap_sync;

   // acquisition state
   rtab_acq_t acq_reg, acq_next;
   logic [SETTLE_W-1:0] cnt_reg, cnt_next;
   logic [5:0] first_reg, first_next;
   logic [4:0] addr_reg, addr_next;
   logic valid_reg, valid_next;
   logic fail_reg, fail_next;

   // message state
   logic active_reg, active_next;
   logic bus_reg, bus_next;
   logic mreset_reg, mreset_next;
   logic rreq_reg, rreq_next;
   logic rbus_reg, rbus_next;
   logic bcast_reg, bcast_next;

   // checker terms
   logic par_ok_x; // parity by reduction
   logic par_ok_c; // parity by bit count
   logic range_ok; // not the broadcast address
   logic [2:0] ones_cnt;
   // command decode terms
   logic hit_a, hit_b, bc_a, bc_b, take_a, take_b;

   // strap pins pass the three-stage filter
   rtab_sync3 #(.WIDTH(6)) u_strap_sync (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .pin_in({strap_parity, strap_addr}),
      .pin_out(strap_sync)
   );

   // two independent checkers on the same captured word
   always_comb begin
      ones_cnt = 3'h0;
      for (int i = 0; i < 6; i++) begin
         ones_cnt = ones_cnt + {2'h0, first_reg[i]};
      end
      par_ok_x = ^first_reg;
      par_ok_c = ones_cnt[0];
      // all-ones is never a unique address
      range_ok = (first_reg[4:0] <= MAX_UNIQUE_ADDR);
   end

   // next values of the acquisition machine
   always_comb begin
      acq_next = acq_reg;
      cnt_next = cnt_reg;
      first_next = first_reg;
      addr_next = addr_reg;
      valid_next = valid_reg;
      fail_next = fail_reg;
      unique case (acq_reg)
         // wait for the wiring to settle, then capture
         ACQ_SETTLE: begin
            if (cnt_reg == SETTLE_LAST) begin
               cnt_next = SETTLE_RST;
               first_next = strap_sync;
               acq_next = ACQ_CONFIRM;
            end else begin
               cnt_next = cnt_reg + 8'h01;
            end
         end
         // second sample must match and pass both checks
         ACQ_CONFIRM: begin
            if (cnt_reg == SETTLE_LAST) begin
               cnt_next = SETTLE_RST;
               // agreement of samples and of both checkers
               if (strap_sync == first_reg && par_ok_x && par_ok_c && range_ok) begin
                  addr_next = first_reg[4:0];
                  valid_next = 1'b1;
                  acq_next = ACQ_VALID;
               end else begin
                  fail_next = 1'b1;
                  acq_next = ACQ_INVALID;
               end
            end else begin
               cnt_next = cnt_reg + 8'h01;
            end
         end
         // address held until the next reset
         ACQ_VALID: begin
            acq_next = ACQ_VALID;
         end
         // silent until the next reset
         ACQ_INVALID: begin
            acq_next = ACQ_INVALID;
         end
      endcase
   end

   // register the acquisition machine
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         acq_reg <= ACQ_SETTLE;
         cnt_reg <= SETTLE_RST;
         first_reg <= 6'h00;
         addr_reg <= 5'h00;
         valid_reg <= 1'b0;
         fail_reg <= 1'b0;
      end else begin
         acq_reg <= acq_next;
         cnt_reg <= cnt_next;
         first_reg <= first_next;
         addr_reg <= addr_next;
         valid_reg <= valid_next;
         fail_reg <= fail_next;
      end
   end

   // command decode against own address and broadcast
   always_comb begin
      hit_a = cmd_valid_a && (cmd_addr_a == addr_reg);
      hit_b = cmd_valid_b && (cmd_addr_b == addr_reg);
      bc_a = cmd_valid_a && (cmd_addr_a == BCAST_ADDR);
      bc_b = cmd_valid_b && (cmd_addr_b == BCAST_ADDR);
      // nothing is taken without a valid address
      // bus a wins if both buses fire in one cycle
      take_a = valid_reg && (hit_a || bc_a);
      take_b = valid_reg && (hit_b || bc_b) && !take_a;
   end

   // next values of the message control
   always_comb begin
      active_next = active_reg;
      bus_next = bus_reg;
      mreset_next = 1'b0;
      rreq_next = 1'b0;
      rbus_next = rbus_reg;
      bcast_next = 1'b0;
      if (take_a || take_b) begin
         // new command on the other bus aborts the old one
         if (active_reg && (bus_reg != (take_b ? BUS_B : BUS_A))) begin
            mreset_next = 1'b1;
         end
         active_next = 1'b1;
         bus_next = take_b ? BUS_B : BUS_A;
         // reply on the bus the command came in on
         rbus_next = take_b ? BUS_B : BUS_A;
         // broadcast gets no reply
         rreq_next = take_a ? !bc_a : !bc_b;
         bcast_next = take_a ? bc_a : bc_b;
      end else if (msg_done) begin
         // current message finished
         active_next = 1'b0;
      end
   end

   // register the message control
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         active_reg <= 1'b0;
         bus_reg <= BUS_A;
         mreset_reg <= 1'b0;
         rreq_reg <= 1'b0;
         rbus_reg <= BUS_A;
         bcast_reg <= 1'b0;
      end else begin
         active_reg <= active_next;
         bus_reg <= bus_next;
         mreset_reg <= mreset_next;
         rreq_reg <= rreq_next;
         rbus_reg <= rbus_next;
         bcast_reg <= bcast_next;
      end
   end

   // outputs straight from flops
   assign addr_valid = valid_reg;
   assign addr_fail = fail_reg;
   assign own_addr = addr_reg;
   assign msg_active = active_reg;
   assign active_bus = bus_reg;
   assign msg_reset = mreset_reg;
   assign reply_req = rreq_reg;
   assign reply_bus = rbus_reg;
   assign bcast_rx = bcast_reg;
endmodule

// [pkg/rtab_pkg.sv]
package rtab_pkg;
   // width of a terminal address
   localparam int ADDR_W = 5;
   // reserved broadcast address
   localparam logic [4:0] BCAST_ADDR = 5'h1F;
   // highest unique address a terminal may take
   localparam logic [4:0] MAX_UNIQUE_ADDR = 5'h1E;
   // clock rate
   localparam int CLK_HZ = 40_000_000;
   // settling time of the strap wiring after reset, in ns
   localparam int SETTLE_NS = 1000;
   // settle count, least time so rounded up, at least one cycle
   localparam int SETTLE_CYC_RAW = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int SETTLE_CYC = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
   // settle counter width and reset value
   localparam int SETTLE_W = 8;
   localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYC - 1);
   localparam logic [7:0] SETTLE_RST = 8'h00;
   // bus identifiers
   localparam logic BUS_A = 1'b0;
   localparam logic BUS_B = 1'b1;
   // reset value of the synchroniser stages
   localparam logic SYNC_RST = 1'b0;
   // address acquisition states, gray along settle, sample, valid
   typedef enum logic [1:0] {
      ACQ_SETTLE  = 2'b00,
      ACQ_CONFIRM = 2'b01,
      ACQ_VALID   = 2'b11,
      ACQ_INVALID = 2'b10
   } rtab_acq_t;
endpackage

// [core/rtab_sync3.sv]
`timescale 1ns/1ps
module rtab_sync3
   import rtab_pkg::*;
#(
   parameter int WIDTH = 6
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // asynchronous pins
   input wire logic [WIDTH-1:0] pin_in,
   // filtered value
   output logic [WIDTH-1:0] pin_out
);
   // three stages, and the agreed value
   logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, out_reg;
   logic [WIDTH-1:0] out_next;

   // a bit changes only when stages two and three agree
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : out_reg[i];
      end
   end

   // register the chain
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         s1_reg <= {WIDTH{SYNC_RST}};
         s2_reg <= {WIDTH{SYNC_RST}};
         s3_reg <= {WIDTH{SYNC_RST}};
         out_reg <= {WIDTH{SYNC_RST}};
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         out_reg <= out_next;
      end
   end

   assign pin_out = out_reg;
endmodule

// [bench/rtab_props_properties.sv]
`timescale 1ns/1ps
module rtab_props
   import rtab_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // straps and commands
   input wire logic [4:0] strap_addr,
   input wire logic strap_parity,
   input wire logic cmd_valid_a,
   input wire logic [4:0] cmd_addr_a,
   input wire logic cmd_valid_b,
   input wire logic [4:0] cmd_addr_b,
   input wire logic msg_done,
   // status and control
   input wire logic addr_valid,
   input wire logic addr_fail,
   input wire logic [4:0] own_addr,
   input wire logic msg_active,
   input wire logic active_bus,
   input wire logic msg_reset,
   input wire logic reply_req,
   input wire logic reply_bus,
   input wire logic bcast_rx
);
   // cycles since reset release, saturating
   logic [7:0] up_reg;
   logic [7:0] up_next;
   always_comb up_next = (up_reg == 8'hFF) ? up_reg : up_reg + 8'h01;
   always_ff @(posedge ref_clk) up_reg <= reset_n ? up_next : 8'h00;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // commands to our own address, a wins a tie
   wire own_a = addr_valid && cmd_valid_a && cmd_addr_a == own_addr;
   wire own_b = addr_valid && cmd_valid_b && cmd_addr_b == own_addr && !cmd_valid_a;
   property p_super; msg_active && !active_bus && own_b |=> msg_reset && reply_bus && active_bus;
   endproperty
   a_super: assert property (p_super)
      else $error("supersede on b not honoured");
   property p_same; msg_active && active_bus && own_b |=> !msg_reset && reply_bus; endproperty
   a_same: assert property (p_same)
      else $error("same bus command aborted");
   property p_reply; own_a |=> reply_req && !reply_bus && !active_bus && msg_active; endproperty
   a_reply: assert property (p_reply)
      else $error("no reply on bus a");
   property p_bcast; addr_valid && cmd_valid_a && cmd_addr_a == BCAST_ADDR |=> bcast_rx && !reply_req;
   endproperty
   a_bcast: assert property (p_bcast)
      else $error("broadcast mishandled");
   property p_mute; !addr_valid |=> !reply_req && !bcast_rx && !msg_active; endproperty
   a_mute: assert property (p_mute)
      else $error("answer without valid address");
   property p_parity; $rose(addr_valid) |-> ^{strap_parity, strap_addr} && own_addr == strap_addr;
   endproperty
   a_parity: assert property (p_parity)
      else $error("address accepted with bad parity");
   // verdict lands on the edge that closes the second settle window
   property p_early; up_reg < 8'(2 * SETTLE_CYC) |-> !addr_valid && !addr_fail; endproperty
   a_early: assert property (p_early)
      else $error("verdict before settle");
   property p_late; up_reg == 8'(2 * SETTLE_CYC) |-> addr_valid ^ addr_fail; endproperty
   a_late: assert property (p_late)
      else $error("no single verdict after settle");
endmodule
bind rtab_core rtab_props u_props (.*);

// [bench/rtab_bc_model.sv]
`timescale 1ns/1ps
module rtab_bc_model (
   // clock
   input wire logic ref_clk,
   // command buses
   output logic cmd_valid_a,
   output logic [4:0] cmd_addr_a,
   output logic cmd_valid_b,
   output logic [4:0] cmd_addr_b
);
   initial begin
      cmd_valid_a = 1'b0;
      cmd_valid_b = 1'b0;
      cmd_addr_a = 5'h0A;
      cmd_addr_b = 5'h15;
   end
   // one bus carries a command at a time
   task automatic send(input logic bus, input logic [4:0] adr);
      @(posedge ref_clk);
      cmd_valid_a <= !bus;
      cmd_valid_b <= bus;
      cmd_addr_a <= bus ? ~adr : adr;
      cmd_addr_b <= bus ? adr : ~adr;
      @(posedge ref_clk);
      // released fields show the inverse, never the old value
      cmd_valid_a <= 1'b0;
      cmd_valid_b <= 1'b0;
      cmd_addr_a <= ~adr;
      cmd_addr_b <= ~adr;
   endtask
endmodule

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
   import rtab_pkg::*;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [4:0] strap_addr = 5'h00;
   logic strap_parity = 1'b0;
   logic msg_done = 1'b0;
   wire logic cmd_valid_a, cmd_valid_b, addr_valid, addr_fail, msg_active, active_bus;
   wire logic msg_reset, reply_req, reply_bus, bcast_rx;
   wire logic [4:0] cmd_addr_a, cmd_addr_b, own_addr;
   int fail_count = 0;
   int num_checks = 0;
   rtab_bc_model bc (.*);
   rtab_core dut (.*);
   initial forever #12.5 ref_clk = ~ref_clk;
   // compare one value
   task automatic chk(input string nm, input logic [4:0] seen, input logic [4:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // reset with given straps, wait bounded for the verdict
   task automatic boot(input logic [4:0] a, input logic p);
      int n;
      @(posedge ref_clk);
      reset_n <= 1'b0;
      strap_addr <= a;
      strap_parity <= p;
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'b1;
      for (n = 0; n < 200 && !(addr_valid === 1'b1 || addr_fail === 1'b1); n++) begin
         @(posedge ref_clk);
         #1;
      end
      if (n == 200) begin
         fail_count++;
         end_of_test();
      end
   endtask
   // boundary, reserved and bad parity straps
   task automatic t_addr;
      logic [4:0] ta [4] = '{5'h00, 5'h1E, 5'h1F, 5'h05};
      logic [3:0] tp = 4'b0011;
      logic [3:0] ok = 4'b0011;
      for (int i = 0; i < 4; i++) begin
         boot(ta[i], tp[i]);
         chk("status", {3'h0, addr_fail, addr_valid}, {3'h0, !ok[i], ok[i]});
         chk("own_addr", own_addr, ok[i] ? ta[i] : 5'h00);
         bc.send(1'b0, ta[i]);
         #1;
         chk("answer", {3'h0, bcast_rx, reply_req}, {4'h0, ok[i]});
      end
      $display("test addr done");
   endtask
   // supersede, same bus restart, broadcast, end of message
   task automatic t_super;
      boot(5'h05, 1'b1);
      bc.send(1'b0, 5'h05);
      #1;
      chk("first", {msg_reset, reply_req, reply_bus, active_bus, msg_active}, 5'h09);
      bc.send(1'b1, 5'h05);
      #1;
      chk("super", {msg_reset, reply_req, reply_bus, active_bus, msg_active}, 5'h1F);
      bc.send(1'b1, 5'h05);
      #1;
      chk("same", {msg_reset, reply_req, reply_bus, active_bus, msg_active}, 5'h0F);
      bc.send(1'b1, 5'h07);
      #1;
      chk("other", {3'h0, reply_req, msg_reset}, 5'h00);
      bc.send(1'b0, BCAST_ADDR);
      #1;
      chk("bcast", {3'h0, bcast_rx, reply_req}, 5'h02);
      @(posedge ref_clk);
      msg_done <= 1'b1;
      @(posedge ref_clk);
      msg_done <= 1'b0;
      #1;
      chk("done", {4'h0, msg_active}, 5'h00);
      $display("test super done");
   endtask
   initial begin
      t_addr();
      t_super();
      end_of_test();
   end
endmodule
